// ==== verilog/mfid_defs.vh ====
// Purpose: Constants for the multifunction input decoder
// Assumes: AXI4-Lite register word-aligned byte addresses, 40 MHz clock
// Notes: Included by every design file
`ifndef MFID_DEFS_VH
`define MFID_DEFS_VH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define MFID_REG_FUNC 12'h000
`define MFID_REG_ACT 12'h004
`define MFID_REG_CFG 12'h008
`define MFID_REG_CMD 12'h00c
`define MFID_REG_STAT 12'h010
`define MFID_REG_PIN 12'h014
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define MFID_FUNC_RST 20'h00000
`define MFID_ACT_RST 15'h0000
`define MFID_CFG_RST 10'h000
// ------------------------------------------------------------
// Config register fields
// ------------------------------------------------------------
`define MFID_CFG_SLOW_LSB 0
`define MFID_CFG_SLOW_MSB 6
`define MFID_CFG_LATCH 7
`define MFID_CFG_FLASH 8
`define MFID_CFG_PROG 9
// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define MFID_ST_INH 0
`define MFID_ST_RELEASE 1
`define MFID_ST_BRK_FAULT 2
`define MFID_ST_THR_FAULT 3
`define MFID_ST_REV 4
`define MFID_ST_PROF2 5
`define MFID_ST_SLOW 6
`define MFID_ST_FWD_BLK 7
`define MFID_ST_REV_BLK 8
// ------------------------------------------------------------
// Functions per pin, 4 bits each
// ------------------------------------------------------------
`define MFID_FN_NONE 4'h0
`define MFID_FN_REVERSE 4'h1
`define MFID_FN_RELEASE 4'h2
`define MFID_FN_CHARGER 4'h3
`define MFID_FN_PROFILE2 4'h4
`define MFID_FN_SLOW 4'h5
`define MFID_FN_SLOWSTOP 4'h6
`define MFID_FN_SS_FWD 4'h7
`define MFID_FN_SS_REV 4'h8
`define MFID_FN_WIPER 4'h9
`define MFID_FN_NEUTRAL 4'ha
// ------------------------------------------------------------
// Active settings per pin, 3 bits each
// ------------------------------------------------------------
`define MFID_ACT_LOW 3'h0
`define MFID_ACT_HIGH 3'h1
`define MFID_ACT_OPEN 3'h2
`define MFID_ACT_LOW_HIGH 3'h3
`define MFID_ACT_LOW_OPEN 3'h4
`define MFID_ACT_HIGH_OPEN 3'h5
// ------------------------------------------------------------
// Pin condition codes
// ------------------------------------------------------------
`define MFID_PIN_OPEN 2'h0
`define MFID_PIN_DOWN 2'h1
`define MFID_PIN_UP 2'h2
`define MFID_PIN_RES 2'h3
// ------------------------------------------------------------
// Timing and flash codes
// ------------------------------------------------------------
`define MFID_DEB_CYCLES 16'h0010
`define MFID_FC_NONE 4'h0
`define MFID_FC_BRAKE 4'h5
`define MFID_FC_INHIBIT 4'h6
`define MFID_FC_THROTTLE 4'h7
`endif

// ==== verilog/mfid_debounce.v ====
// Purpose: Synchronise and debounce one pin condition code
// Assumes: Input is asynchronous to clk
// Notes: Output changes only after a stable run of DEB_CYCLES
`timescale 1ns/10ps
`default_nettype none
`include "mfid_defs.vh"
module mfid_debounce #(
   parameter [15:0] DEB_CYCLES = `MFID_DEB_CYCLES
)
(
   input wire clk,
   input wire rst,
   input wire ce,
   input wire [1:0] pin_in,
   output reg [1:0] pin_out
);
   reg [1:0] sync1_r;
   reg [1:0] sync2_r;
   reg [1:0] last_r;
   reg [15:0] cnt_r;
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_r <= 2'h0;
         sync2_r <= 2'h0;
         last_r <= 2'h0;
         cnt_r <= 16'h0000;
         pin_out <= 2'h0;
      end
      else if (ce)
      begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         last_r <= sync2_r;
         if (sync2_r != last_r)
            cnt_r <= 16'h0000;
         else if (cnt_r >= DEB_CYCLES)
            pin_out <= last_r;
         else
            cnt_r <= cnt_r + 16'h0001;
      end
   end
endmodule // mfid_debounce
`default_nettype wire

// ==== verilog/mfid_active.v ====
// Purpose: Decode one pin condition against its active setting
// Assumes: Registered output, one cycle latency
// Notes: Resistive pull counts as pulled to its rail for plain levels
`timescale 1ns/10ps
`default_nettype none
`include "mfid_defs.vh"
module mfid_active
(
   input wire clk,
   input wire rst,
   input wire ce,
   input wire [1:0] cond,
   input wire [2:0] act,
   input wire high_rail,
   output reg asserted,
   output reg full
);
   reg dn;
   reg up;
   reg op;
   reg a_nxt;
   always @*
   begin
      op = (cond == `MFID_PIN_OPEN);
      dn = (cond == `MFID_PIN_DOWN) ||
           ((cond == `MFID_PIN_RES) && !high_rail);
      up = (cond == `MFID_PIN_UP) ||
           ((cond == `MFID_PIN_RES) && high_rail);
      case (act)
         `MFID_ACT_LOW: a_nxt = dn;
         `MFID_ACT_HIGH: a_nxt = up;
         `MFID_ACT_OPEN: a_nxt = op;
         `MFID_ACT_LOW_HIGH: a_nxt = !op;
         `MFID_ACT_LOW_OPEN: a_nxt = !up;
         `MFID_ACT_HIGH_OPEN: a_nxt = !dn;
         default: a_nxt = 1'b0;
      endcase
   end
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         asserted <= 1'b0;
         full <= 1'b0;
      end
      else if (ce)
      begin
         asserted <= a_nxt;
         full <= a_nxt && (cond != `MFID_PIN_RES);
      end
   end
endmodule // mfid_active
`default_nettype wire

// ==== verilog/mfid_top.v ====
// Purpose: Multifunction input decoder with AXI4-Lite registers
// Assumes: 40 MHz clk, asynchronous active-high rst
// Notes: Five input pins, each with function and active setting
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "mfid_defs.vh"
module mfid_top #(
   parameter NPIN = 5,
   parameter [15:0] DEB_CYCLES = `MFID_DEB_CYCLES
)
(
   input wire clk,
   input wire rst,
   input wire ce,
   input wire [2*NPIN-1:0] pin_cond,
   input wire throttle_out_neutral,
   input wire throttle_reverse,
   input wire moving,
   input wire push_over_limit,
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg dir_reverse,
   output reg drive_enable,
   output reg emergency_decel,
   output reg brake_release,
   output reg profile2,
   output reg slow_active,
   output reg [6:0] speed_cap_pct,
   output reg [3:0] flash_code
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg [4*NPIN-1:0] func_r;
   reg [3*NPIN-1:0] act_r;
   reg [9:0] cfg_r;
   reg [8:0] stat_w;
   reg [11:0] awaddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg aw_have_r;
   reg w_have_r;
   wire [6:0] slow_pct = cfg_r[`MFID_CFG_SLOW_MSB:`MFID_CFG_SLOW_LSB];
   wire latch_en = cfg_r[`MFID_CFG_LATCH];
   wire flash_en = cfg_r[`MFID_CFG_FLASH];
   wire prog_sess = cfg_r[`MFID_CFG_PROG];
   // ------------------------------------------------------------
   // Per pin decode
   // ------------------------------------------------------------
   wire [2*NPIN-1:0] cond_d;
   wire [NPIN-1:0] asrt;
   wire [NPIN-1:0] full;
   wire [NPIN-1:0] ss_ok;
   wire [NPIN-1:0] nd_ok;
   genvar g;
   generate
      for (g = 0; g < NPIN; g = g + 1)
      begin : g_pin
         mfid_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb
         (
            .clk(clk),
            .rst(rst),
            .ce(ce),
            .pin_in(pin_cond[2*g+1:2*g]),
            .pin_out(cond_d[2*g+1:2*g])
         );
         mfid_active u_act
         (
            .clk(clk),
            .rst(rst),
            .ce(ce),
            .cond(cond_d[2*g+1:2*g]),
            .act(act_r[3*g+2:3*g]),
            .high_rail(act_r[3*g+2:3*g] == `MFID_ACT_HIGH),
            .asserted(asrt[g]),
            .full(full[g])
         );
         assign ss_ok[g] = (act_r[3*g+2:3*g] == `MFID_ACT_LOW) ||
                           (act_r[3*g+2:3*g] == `MFID_ACT_HIGH);
         assign nd_ok[g] = ss_ok[g] ||
                           (act_r[3*g+2:3*g] == `MFID_ACT_OPEN);
      end
   endgenerate
   // ------------------------------------------------------------
   // Function gathering
   // ------------------------------------------------------------
   reg f_rev;
   reg f_rel;
   reg f_stop;
   reg f_slow;
   reg f_prof;
   reg f_fstop;
   reg f_fslow;
   reg f_rstop;
   reg f_rslow;
   reg f_neut;
   reg f_nbad;
   integer i;
   always @*
   begin
      f_rev = 1'b0;
      f_rel = 1'b0;
      f_stop = 1'b0;
      f_slow = 1'b0;
      f_prof = 1'b0;
      f_fstop = 1'b0;
      f_fslow = 1'b0;
      f_rstop = 1'b0;
      f_rslow = 1'b0;
      f_neut = 1'b0;
      f_nbad = 1'b0;
      for (i = 0; i < NPIN; i = i + 1)
      begin
         case (func_r[4*i +: 4])
            `MFID_FN_REVERSE: f_rev = f_rev | asrt[i];
            `MFID_FN_RELEASE: f_rel = f_rel | asrt[i];
            `MFID_FN_CHARGER: f_stop = f_stop | asrt[i];
            `MFID_FN_PROFILE2: f_prof = f_prof | asrt[i];
            `MFID_FN_SLOW:
            begin
               f_slow = f_slow | asrt[i];
               f_stop = f_stop | (asrt[i] && slow_pct == 7'h00);
            end
            `MFID_FN_SLOWSTOP:
            begin
               f_stop = f_stop | (ss_ok[i] & full[i]);
               f_slow = f_slow | (ss_ok[i] & asrt[i] & ~full[i]);
            end
            `MFID_FN_SS_FWD:
            begin
               f_fstop = f_fstop | (ss_ok[i] & full[i]);
               f_fslow = f_fslow | (ss_ok[i] & asrt[i] & ~full[i]);
            end
            `MFID_FN_SS_REV:
            begin
               f_rstop = f_rstop | (ss_ok[i] & full[i]);
               f_rslow = f_rslow | (ss_ok[i] & asrt[i] & ~full[i]);
            end
            `MFID_FN_NEUTRAL:
            begin
               f_neut = f_neut | (nd_ok[i] & asrt[i]);
               f_nbad = f_nbad | ~nd_ok[i];
            end
            default: f_neut = f_neut;
         endcase
      end
   end
   // ------------------------------------------------------------
   // Drive state
   // ------------------------------------------------------------
   reg first_r;
   reg inh_latch_r;
   reg brk_dis_r;
   reg brk_fault_r;
   reg thr_fault_r;
   reg fwd_blk_r;
   reg rev_blk_r;
   reg push_stop_r;
   reg rel_q_r;
   wire inhibit = f_stop | inh_latch_r;
   wire rel_ok = f_rel & rel_q_r & ~brk_dis_r & ~inhibit & ~prog_sess;
   wire at_rest = ~moving & ~throttle_out_neutral;
   wire dir_nxt = throttle_reverse ^ f_rev;
   wire dir_blk = dir_nxt ? (f_rstop | rev_blk_r) : (f_fstop | fwd_blk_r);
   wire dir_slow = dir_nxt ? f_rslow : f_fslow;
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         first_r <= 1'b1;
         inh_latch_r <= 1'b0;
         brk_dis_r <= 1'b0;
         brk_fault_r <= 1'b0;
         thr_fault_r <= 1'b0;
         fwd_blk_r <= 1'b0;
         rev_blk_r <= 1'b0;
         push_stop_r <= 1'b0;
         rel_q_r <= 1'b0;
         dir_reverse <= 1'b0;
         drive_enable <= 1'b0;
         emergency_decel <= 1'b0;
         brake_release <= 1'b0;
         profile2 <= 1'b0;
         slow_active <= 1'b0;
         speed_cap_pct <= 7'h00;
         flash_code <= `MFID_FC_NONE;
      end
      else if (ce)
      begin
         first_r <= 1'b0;
         rel_q_r <= f_rel;
         if (f_stop && latch_en)
            inh_latch_r <= 1'b1;
         if (f_rel && (first_r || (moving && !rel_q_r)) && !brk_dis_r)
         begin
            brk_dis_r <= 1'b1;
            brk_fault_r <= 1'b1;
         end
         if ((f_neut && throttle_out_neutral) || f_nbad)
            thr_fault_r <= 1'b1;
         if (f_fstop)
            fwd_blk_r <= 1'b1;
         else if (latch_en == 1'b0 && at_rest)
            fwd_blk_r <= 1'b0;
         if (f_rstop)
            rev_blk_r <= 1'b1;
         else if (latch_en == 1'b0 && at_rest)
            rev_blk_r <= 1'b0;
         if (rel_ok && push_over_limit)
            push_stop_r <= 1'b1;
         else if (!rel_ok)
            push_stop_r <= 1'b0;
         // Direction change ramps at normal rate in the drive logic
         dir_reverse <= dir_nxt;
         brake_release <= rel_ok & ~push_stop_r;
         drive_enable <= ~inhibit & ~rel_ok & ~thr_fault_r & ~dir_blk;
         emergency_decel <= inhibit | dir_blk;
         profile2 <= f_prof;
         slow_active <= f_slow | dir_slow;
         speed_cap_pct <= (f_slow | dir_slow) ? slow_pct : 7'h64;
         if (thr_fault_r)
            flash_code <= `MFID_FC_THROTTLE;
         else if (inhibit && flash_en)
            flash_code <= `MFID_FC_INHIBIT;
         else if (brk_fault_r)
            flash_code <= `MFID_FC_BRAKE;
         else
            flash_code <= `MFID_FC_NONE;
      end
   end
   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   always @*
   begin
      stat_w = 9'h000;
      stat_w[`MFID_ST_INH] = inhibit;
      stat_w[`MFID_ST_RELEASE] = rel_ok;
      stat_w[`MFID_ST_BRK_FAULT] = brk_fault_r;
      stat_w[`MFID_ST_THR_FAULT] = thr_fault_r;
      stat_w[`MFID_ST_REV] = dir_nxt;
      stat_w[`MFID_ST_PROF2] = f_prof;
      stat_w[`MFID_ST_SLOW] = f_slow;
      stat_w[`MFID_ST_FWD_BLK] = fwd_blk_r;
      stat_w[`MFID_ST_REV_BLK] = rev_blk_r;
   end
   wire wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= 12'h000;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h00000000;
         func_r <= `MFID_FUNC_RST;
         act_r <= `MFID_ACT_RST;
         cfg_r <= `MFID_CFG_RST;
      end
      else if (ce)
      begin
         s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awready && s_axi_awvalid)
         begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wready && s_axi_wvalid)
         begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            case (awaddr_r & 12'hffc)
               `MFID_REG_FUNC:
                  if (wstrb_r == 4'hf)
                     func_r <= wdata_r[4*NPIN-1:0];
               `MFID_REG_ACT:
                  if (wstrb_r == 4'hf)
                     act_r <= wdata_r[3*NPIN-1:0];
               `MFID_REG_CFG:
                  if (wstrb_r == 4'hf)
                     cfg_r <= wdata_r[9:0];
               `MFID_REG_CMD:
                  s_axi_bresp <= 2'h0;
               default: s_axi_bresp <= 2'h2;
            endcase
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arready && s_axi_arvalid)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h00000000;
            case (s_axi_araddr & 12'hffc)
               `MFID_REG_FUNC: s_axi_rdata[4*NPIN-1:0] <= func_r;
               `MFID_REG_ACT: s_axi_rdata[3*NPIN-1:0] <= act_r;
               `MFID_REG_CFG: s_axi_rdata[9:0] <= cfg_r;
               `MFID_REG_CMD: s_axi_rdata <= 32'h00000000;
               `MFID_REG_STAT: s_axi_rdata[8:0] <= stat_w;
               `MFID_REG_PIN: s_axi_rdata[2*NPIN-1:0] <= cond_d;
               default: s_axi_rresp <= 2'h2;
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule // mfid_top
`default_nettype wire

// ==== verification/mfid_partner.sv ====
// Purpose: Tiller switch model driving the input pins
// Assumes: Bench commands the settled pin conditions
// Notes: Every change bounces for three cycles before settling
`timescale 1ns/10ps
`default_nettype none
module mfid_partner
(
   input wire logic clk,
   input wire logic [9:0] sw_cmd,
   output logic [9:0] pin_cond
);
   logic [9:0] last_r = 10'h0;
   logic [1:0] cnt_r = 2'h0;
   initial pin_cond = 10'h0;
   // ---------------------------------------------
   // Contact bounce, then the commanded condition
   // ---------------------------------------------
   always @(posedge clk)
   begin
      last_r <= sw_cmd;
      if (sw_cmd != last_r)
         cnt_r <= 2'h3;
      else if (cnt_r != 2'h0)
         cnt_r <= cnt_r - 2'h1;
      if (cnt_r != 2'h0)
         pin_cond <= ~pin_cond;
      else
         pin_cond <= last_r;
   end
endmodule // mfid_partner
`default_nettype wire

// ==== verification/mfid_chk.sv ====
// Purpose: Port checks for the input decoder
// Assumes: One clock, rst asynchronous active high
// Notes: Bound into mfid_top
`timescale 1ns/10ps
`default_nettype none
module mfid_chk
(
   input wire logic clk,
   input wire logic rst,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic drive_enable,
   input wire logic emergency_decel,
   input wire logic brake_release,
   input wire logic [3:0] flash_code
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   AST_RST_IDLE: assert property (disable iff (1'h0)
      $fell(rst) |-> !drive_enable && flash_code == 4'h0)
      else $error("outputs busy after reset");
   AST_REL_NO_DRIVE: assert property (
      brake_release |-> !drive_enable) else $error("drive while released");
   AST_THR_HELD: assert property (
      flash_code == 4'h7 |=> flash_code == 4'h7) else $error("fault dropped");
   AST_THR_NO_DRIVE: assert property (
      flash_code == 4'h7 |-> !drive_enable) else $error("drive in fault");
   AST_BRK_FAULT: assert property (
      flash_code == 4'h5 |-> !brake_release) else $error("release in fault");
   AST_INH_FLASH: assert property (
      flash_code == 4'h6 |-> !drive_enable && !brake_release)
      else $error("inhibit not kept");
   AST_INH_DECEL: assert property (
      flash_code == 4'h6 |-> emergency_decel) else $error("no emergency");
   AST_BRESP_HOLD: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   AST_RVALID_LAT: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("late read data");
endmodule // mfid_chk
bind mfid_top mfid_chk mfid_chk_i (.clk, .rst, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .drive_enable, .emergency_decel, .brake_release, .flash_code);
`default_nettype wire

// ==== verification/tb_mfid_top.sv ====
// Purpose: Self-checking bench for the input decoder
// Assumes: Debounce shortened to two cycles
// Notes: Registers reached over AXI4-Lite
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) \
   begin \
      n_checks++; \
      if ((g) !== (e)) \
      begin \
         bad_count++; \
         $display("ERROR %s expected %0h seen %0h", n, e, g); \
      end \
   end
module tb_mfid_top;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic ce = 1'h1;
   logic [9:0] sw = 10'h0;
   wire [9:0] pin_cond;
   logic throttle_out_neutral = 1'h0, throttle_reverse = 1'h0;
   logic moving = 1'h0, push_over_limit = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, d, v;
   logic [1:0] r;
   logic dir_reverse, drive_enable, emergency_decel, brake_release;
   logic profile2, slow_active;
   logic [6:0] speed_cap_pct;
   logic [3:0] flash_code;
   int bad_count = 0, n_checks = 0, cyc = 0, seed = 32'h84fb;
   mfid_top #(.NPIN(5), .DEB_CYCLES(16'h0002)) mfid_top_i (.clk, .rst,
      .ce, .pin_cond, .throttle_out_neutral, .throttle_reverse, .moving,
      .push_over_limit, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .dir_reverse, .drive_enable,
      .emergency_decel, .brake_release, .profile2, .slow_active,
      .speed_cap_pct, .flash_code);
   mfid_partner mfid_partner_i (.clk, .sw_cmd(sw), .pin_cond);
   // ---------------------------------------------
   // Clock, watchdog and helpers
   // ---------------------------------------------
   initial forever #12.5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         bad_count++;
         summarize;
      end
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] x);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= x;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end
      while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   task automatic cfg(input logic [31:0] f, a, c);
      wr(12'h000, f);
      wr(12'h004, a);
      wr(12'h008, c);
   endtask
   task automatic settle;
      repeat (16) @(posedge clk);
   endtask
   task automatic rst_dut;
      sw <= 10'h0;
      moving <= 1'h0;
      throttle_out_neutral <= 1'h0;
      rst <= 1'h1;
      repeat (16) @(posedge clk);
      rst <= 1'h0;
   endtask
   function automatic logic act_exp(input logic [2:0] a, input logic [1:0] c);
      case (a)
         3'h0: act_exp = (c == 2'h1);
         3'h1: act_exp = (c == 2'h2);
         3'h2: act_exp = (c == 2'h0);
         3'h3: act_exp = (c != 2'h0);
         3'h4: act_exp = (c != 2'h2);
         default: act_exp = (c != 2'h1);
      endcase
   endfunction
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial
   begin
      int a, c, i;
      rst_dut;
      for (i = 0; i < 4; i++)
      begin
         rd(12'(i * 4));
         `CHK("reg_reset", 32'h0, d)
         `CHK("reg_resp", 2'h0, r)
      end
      rd(12'h020);
      `CHK("unmapped", 2'h2, r)
      wr(12'h020, 32'h0);
      `CHK("wr_unmapped", 2'h2, r)
      v = $random(seed) & 32'h000fffff;
      wr(12'h000, v);
      s_axi_wstrb <= 4'h1;
      wr(12'h000, ~v);
      s_axi_wstrb <= 4'hf;
      rd(12'h000);
      `CHK("func_rw", v, d)
      $display("register test done");
      for (a = 0; a < 6; a++)
         for (c = 0; c < 3; c++)
         begin
            cfg(32'h4, a, 32'h0);
            sw <= {8'($random(seed)), 2'(c)};
            settle;
            `CHK("profile2", act_exp(3'(a), 2'(c)), profile2)
         end
      ce <= 1'h0;
      sw <= 10'h1;
      settle;
      `CHK("ce_freeze", 1'h1, profile2)
      ce <= 1'h1;
      settle;
      `CHK("ce_run", 1'h0, profile2)
      cfg(32'h11, 32'h9, 32'h0);
      for (i = 0; i < 8; i++)
      begin
         sw <= {6'h0, i[1] ? 2'h2 : 2'h0, i[0] ? 2'h2 : 2'h0};
         throttle_reverse <= i[2];
         settle;
         `CHK("dir", i[2] ^ (i[0] | i[1]), dir_reverse)
      end
      $display("decode test done");
      cfg(32'h6, 32'h1, 32'h132);
      for (i = 0; i < 3; i++)
      begin
         c = (i == 0) ? 3 : (i == 1) ? 2 : 0;
         sw <= 10'(c);
         settle;
         `CHK("slow", c == 3, slow_active)
         `CHK("stop", c == 2, emergency_decel)
         `CHK("cap", (c == 3) ? 7'h32 : 7'h64, speed_cap_pct)
         `CHK("flash", (c == 2) ? 4'h6 : 4'h0, flash_code)
      end
      cfg(32'h6, 32'h2, 32'h100);
      sw <= 10'h0;
      settle;
      `CHK("ss_open", 1'h0, emergency_decel | slow_active)
      cfg(32'h5, 32'h1, 32'h100);
      sw <= 10'h2;
      settle;
      `CHK("slow0", 4'h6, flash_code)
      wr(12'h008, 32'h105);
      settle;
      `CHK("slow5", 4'h0, flash_code)
      `CHK("slow5_cap", 7'h05, speed_cap_pct)
      `CHK("drive_on", 1'h1, drive_enable)
      cfg(32'h23, 32'h8, 32'h180);
      sw <= 10'h1;
      settle;
      sw <= 10'h8;
      settle;
      `CHK("latched", 1'h1, emergency_decel)
      `CHK("no_release", 1'h0, brake_release)
      $display("inhibit test done");
      rst_dut;
      cfg(32'h20, 32'h8, 32'h0);
      sw <= 10'h8;
      settle;
      `CHK("release", 1'h1, brake_release)
      `CHK("rel_drive", 1'h0, drive_enable)
      moving <= 1'h1;
      settle;
      `CHK("pushing", 1'h1, brake_release)
      `CHK("push_flash", 4'h0, flash_code)
      push_over_limit <= 1'h1;
      settle;
      `CHK("push_stop", 1'h0, brake_release)
      push_over_limit <= 1'h0;
      sw <= 10'h0;
      moving <= 1'h1;
      settle;
      sw <= 10'h8;
      settle;
      `CHK("brake_fault", 4'h5, flash_code)
      `CHK("fault_drive", 1'h1, drive_enable)
      moving <= 1'h0;
      settle;
      `CHK("pin_ignored", 1'h0, brake_release)
      for (i = 0; i < 2; i++)
      begin
         rst_dut;
         cfg(32'ha, i ? 32'h3 : 32'h1, 32'h0);
         sw <= 10'h2;
         throttle_out_neutral <= 1'h1;
         settle;
         sw <= 10'h0;
         throttle_out_neutral <= 1'h0;
         settle;
         `CHK("thr_fault", 4'h7, flash_code)
         `CHK("thr_drive", 1'h0, drive_enable)
      end
      for (i = 0; i < 2; i++)
      begin
         rst_dut;
         cfg(i ? 32'h8 : 32'h7, 32'h1, 32'h100);
         throttle_reverse <= i[0];
         moving <= 1'h1;
         sw <= 10'h2;
         settle;
         rd(12'h010);
         `CHK("dir_block", i ? 2'h2 : 2'h1, d[8:7])
         `CHK("dir_flash", 4'h0, flash_code)
         sw <= 10'h0;
         settle;
         rd(12'h010);
         `CHK("block_held", i ? 2'h2 : 2'h1, d[8:7])
         moving <= 1'h0;
         settle;
         rd(12'h010);
         `CHK("block_clear", 2'h0, d[8:7])
      end
      $display("fault test done");
      summarize;
   end
endmodule // tb_mfid_top
`default_nettype wire
